// *** alu_sub_xor_swap_sleep_ops_test.sv ***
// Self-checking bench for the datapath, driven over its register bus.
// Assumes asx_pkg, asx_core and the checker are compiled first.
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin errors++; \
  $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module alu_sub_xor_swap_sleep_ops_test;
  import asx_pkg::*;
  // Row: op, dest, file address, literal, W, file value, C in, W out, file out, flags
  typedef struct packed {
    logic [3:0] op;
    logic [3:0] d;
    logic [7:0] f;
    logic [7:0] lit;
    logic [7:0] w;
    logic [7:0] fv;
    logic [3:0] c;
    logic [7:0] ew;
    logic [7:0] ef;
    logic [3:0] est;
  } asx_row_t;
  asx_row_t rows [13] = '{64'h1_0_00_00_11_33_0_22_33_3, 64'h1_1_7F_00_01_10_0_01_0F_1,
    64'h1_0_00_00_05_05_0_00_05_7, 64'h1_0_00_00_02_01_1_FF_01_0,
    64'h2_1_7F_00_0F_10_0_0F_00_5, 64'h2_0_00_00_10_20_1_10_20_3,
    64'h3_1_00_00_3C_A5_1_3C_5A_1, 64'h3_0_7F_00_3C_A5_1_5A_A5_1,
    64'h4_0_00_F0_0F_11_1_FF_11_1, 64'h4_0_00_55_55_11_0_00_11_4,
    64'h5_1_7F_00_0F_FF_1_0F_F0_1, 64'h5_0_00_00_3C_3C_0_00_3C_4,
    64'h0_1_00_00_66_77_1_66_77_1};
  // Bench-driven inputs, valued from time zero
  logic        clk = 1'h0;
  logic        rst = 1'h1;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  // Design outputs
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, rd;
  logic [7:0]  port_a_direction, port_b_direction, port_c_direction;
  logic        sleep_mode, power_down_flag, timeout_flag;
  logic [1:0]  rs;
  int          errors = 0, n_compared = 0, k;

  asx_core u_dut (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .port_a_direction, .port_b_direction, .port_c_direction, .sleep_mode,
    .power_down_flag, .timeout_flag);

  // 200 MHz clock
  always #2.5 clk = ~clk;

  task summarize;
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize

  task tmo;
    errors++;
    $display("unexpected at %0t: bus wait ran out", $time);
    summarize();
  endtask : tmo

  // Write; ready for the answer is raised a cycle late so hold-up is exercised
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int i;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    for (i = 0; i < 64; i++) begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid && s_axi_bready) break;
      if (s_axi_bvalid) s_axi_bready <= 1'h1;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
    if (i == 64) tmo();
  endtask : axw

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int i;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    for (i = 0; i < 64; i++) begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid && s_axi_rready) break;
      if (s_axi_rvalid) s_axi_rready <= 1'h1;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
    if (i == 64) tmo();
  endtask : axr

  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    `CHK({port_a_direction, port_b_direction, port_c_direction}, {3{ASX_DIR_RESET}})
    `CHK({sleep_mode, power_down_flag, timeout_flag}, 3'h3)
    axr(ASX_STATUS_ADDR, rd, rs);
    `CHK(rd[5:0], 6'h18)
    // Table of arithmetic and logic cases
    foreach (rows[j]) begin
      axw(ASX_W_ADDR, {24'h0, rows[j].w}, rs);
      axw(ASX_STATUS_ADDR, {31'h0, rows[j].c[0]}, rs);
      axw(ASX_FSEL_ADDR, {24'h0, rows[j].f}, rs);
      axw(ASX_FDATA_ADDR, {24'h0, rows[j].fv}, rs);
      axw(ASX_CMD_ADDR, {8'h0, rows[j].lit, rows[j].f, 3'h0, rows[j].d[0], rows[j].op}, rs);
      axr(ASX_W_ADDR, rd, rs);
      `CHK(rd[7:0], rows[j].ew)
      axr(ASX_FDATA_ADDR, rd, rs);
      `CHK(rd[7:0], rows[j].ef)
      axr(ASX_STATUS_ADDR, rd, rs);
      `CHK(rd[2:0], rows[j].est[2:0])
    end
    // Direction load, operand 4 must be ignored
    axw(ASX_STATUS_ADDR, 32'h7, rs);
    for (k = 4; k < 8; k++) begin
      axw(ASX_W_ADDR, 32'h50 + k, rs);
      axw(ASX_CMD_ADDR, {16'h0, 8'(k), 8'h06}, rs);
      `CHK(port_a_direction, (k >= 5) ? 8'h55 : 8'hFF)
      `CHK(port_b_direction, (k >= 6) ? 8'h56 : 8'hFF)
      `CHK(port_c_direction, (k == 7) ? 8'h57 : 8'hFF)
    end
    axr(ASX_STATUS_ADDR, rd, rs);
    `CHK(rd[2:0], 3'h7)
    // Sleep after the watchdog has run for well over one prescaler turn
    axw(ASX_CMD_ADDR, 32'h7, rs);
    `CHK({sleep_mode, power_down_flag, timeout_flag}, 3'h5)
    axr(ASX_WDOG_ADDR, rd, rs);
    `CHK(rd[7:0], ASX_WDOG_RESET)
    // Cleared prescaler: first counter step lands 256 clocks after sleep
    repeat (240) @(posedge clk);
    axr(ASX_WDOG_ADDR, rd, rs);
    `CHK(rd[7:0], ASX_WDOG_RESET)
    repeat (10) @(posedge clk);
    axr(ASX_WDOG_ADDR, rd, rs);
    `CHK(rd[7:0], 8'h01)
    axw(ASX_CMD_ADDR, 32'h0506, rs);
    `CHK(port_a_direction, 8'h55)
    axw(ASX_STATUS_ADDR, 32'h100, rs);
    `CHK(sleep_mode, 1'h0)
    // Unmapped place refused both ways
    axw(8'h24, 32'h1, rs);
    `CHK(rs, ASX_RESP_SLVERR)
    axr(8'h24, rd, rs);
    `CHK({rs, rd}, {ASX_RESP_SLVERR, 32'h0})
    // Reset in mid-run brings the direction, sleep and power, W and status reset values back
    @(posedge clk);
    rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    `CHK({port_a_direction, port_b_direction, port_c_direction}, {3{ASX_DIR_RESET}})
    `CHK({sleep_mode, power_down_flag, timeout_flag}, 3'h3)
    axr(ASX_W_ADDR, rd, rs);
    `CHK(rd, {24'h0, ASX_W_RESET})
    axr(ASX_STATUS_ADDR, rd, rs);
    `CHK(rd[5:0], 6'h18)
    summarize();
  end
endmodule : alu_sub_xor_swap_sleep_ops_test

// *** asx_alu.sv ***
// Combinational result and flag logic for the datapath operations.
// Assumes the caller registers every output it uses.
`timescale 1ns/1ps
module asx_alu
  import asx_pkg::*;
(
  // Operation and operands
  input  wire asx_op_t    op,
  input  wire logic [7:0] w_val,
  input  wire logic [7:0] f_val,
  input  wire logic [7:0] lit,
  input  wire logic       carry_in,
  // Results
  output logic [7:0] result,
  output logic       carry_out,
  output logic       digit_carry_out,
  output logic       zero_out,
  output logic       upd_carries,
  output logic       upd_zero
);

  logic [8:0] diff;
  logic [4:0] ndiff;
  logic       borrow;

  // Subtract in nine bits so the top bit is the borrow out
  always_comb begin
    borrow = (op == ASX_OP_FILE_SUBTRACT_BORROW) ? ~carry_in : 1'b0;
    diff   = {1'b0, f_val} - {1'b0, w_val} - {8'h00, borrow};
    ndiff  = {1'b0, f_val[3:0]} - {1'b0, w_val[3:0]} - {4'h0, borrow};
  end

  // Result and flag update per operation
  always_comb begin
    result      = 8'h00;
    upd_carries = 1'b0;
    upd_zero    = 1'b0;
    case (op)
      ASX_OP_FILE_SUBTRACT, ASX_OP_FILE_SUBTRACT_BORROW: begin
        result      = diff[7:0];
        upd_carries = 1'b1;
        upd_zero    = 1'b1;
      end
      ASX_OP_NIBBLE_SWAP: result = {f_val[3:0], f_val[7:4]};
      ASX_OP_LITERAL_XOR: begin
        result   = w_val ^ lit;
        upd_zero = 1'b1;
      end
      ASX_OP_FILE_XOR: begin
        result   = w_val ^ f_val;
        upd_zero = 1'b1;
      end
      default: result = 8'h00;
    endcase
  end

  // Carry is set unless a borrow was needed
  assign carry_out       = ~diff[8];
  assign digit_carry_out = ~ndiff[4];
  assign zero_out        = (result == 8'h00);

endmodule : asx_alu

// *** asx_core.sv ***
// Datapath for subtract, subtract with borrow, nibble swap, XOR, direction load
// and sleep, driven by software over AXI4-Lite.
// Assumes a single clock, synchronous active-high reset, one access of each kind
// outstanding at a time.
//
// Design decisions made here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
// Contract
// - Sleep clears the power-down flag
// - Sleep sets the time-out flag
// - Sleep zeroes watchdog counter and prescaler
// - After sleep, execution halts until wake
// - File subtract computes f minus W
// - Carry and digit carry mean no borrow
// - Borrow subtract also removes inverted carry
// - Destination bit picks W or file
// - Nibble swap exchanges halves, flags untouched
// - Literal XOR into W, zero flag only
// - File XOR to destination, zero only
// - Direction load copies W for 5,6,7
module asx_core
  import asx_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // AXI4-Lite write address and data
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Port direction and core state
  output logic [7:0]       port_a_direction,
  output logic [7:0]       port_b_direction,
  output logic [7:0]       port_c_direction,
  output logic             sleep_mode,
  output logic             power_down_flag,
  output logic             timeout_flag
);

  // Held write channels
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  // Core state
  logic [7:0]  w_reg;
  logic        carry_flag;
  logic        digit_carry_flag;
  logic        zero_flag;
  logic [31:0] cmd_reg;
  logic [6:0]  file_sel;
  logic [7:0]  file_mem [128];
  logic [7:0]  watchdog_counter;
  logic [7:0]  watchdog_prescaler;
  // Decode
  logic        do_write;
  logic [31:0] next_cmd;
  asx_op_t     cmd_op;
  logic        cmd_dest;
  logic [6:0]  cmd_f;
  logic [7:0]  cmd_lit;
  logic        exec;
  logic [7:0]  alu_result;
  logic        alu_c;
  logic        alu_dc;
  logic        alu_z;
  logic        alu_upd_c;
  logic        alu_upd_z;
  logic        file_op;
  logic        to_file;
  logic        to_w;
  logic        wake;
  logic        sleep_exec;

  // Merge a write into a word under its byte strobes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) r[8*i +: 8] = nw[8*i +: 8];
    end
    return r;
  endfunction : merge

  // Whether an address is one of ours
  function automatic logic mapped(input logic [7:0] a);
    return (a <= ASX_WDOG_ADDR) && (a[1:0] == 2'b00);
  endfunction : mapped

  // Both write channels held and no response pending
  assign do_write = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  assign next_cmd = merge(cmd_reg, w_data, w_strb);
  assign cmd_op   = asx_op_t'(next_cmd[ASX_CMD_OP_LSB +: 4]);
  assign cmd_dest = next_cmd[ASX_CMD_DEST_BIT];
  assign cmd_f    = next_cmd[ASX_CMD_F_LSB +: 7];
  assign cmd_lit  = next_cmd[ASX_CMD_LIT_LSB +: 8];
  // Commands written while asleep are stored but not run
  assign exec     = do_write & (aw_addr == ASX_CMD_ADDR) & ~sleep_mode;
  assign file_op  = (cmd_op == ASX_OP_FILE_SUBTRACT) | (cmd_op == ASX_OP_FILE_SUBTRACT_BORROW)
                  | (cmd_op == ASX_OP_NIBBLE_SWAP) | (cmd_op == ASX_OP_FILE_XOR);
  assign to_file  = exec & file_op & cmd_dest;
  assign to_w     = exec & ((file_op & ~cmd_dest) | (cmd_op == ASX_OP_LITERAL_XOR));
  assign wake     = do_write & (aw_addr == ASX_STATUS_ADDR) & w_strb[1]
                  & w_data[ASX_ST_WAKE];
  // Sleep runs like any other command, so it is also refused while asleep
  assign sleep_exec = exec & (cmd_op == ASX_OP_SLEEP);

  asx_alu u_alu (
    .op              (cmd_op),
    .w_val           (w_reg),
    .f_val           (file_mem[cmd_f]),
    .lit             (cmd_lit),
    .carry_in        (carry_flag),
    .result          (alu_result),
    .carry_out       (alu_c),
    .digit_carry_out (alu_dc),
    .zero_out        (alu_z),
    .upd_carries     (alu_upd_c),
    .upd_zero        (alu_upd_z)
  );

  // Write address and data channels, taken in either order
  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_addr       <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
      end
      // Reopen only after the response is taken: one write at a time
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Write response
  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= ASX_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      // Unmapped or unaligned places answer an error and change nothing
      s_axi_bresp  <= mapped(aw_addr) ? ASX_RESP_OKAY : ASX_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Command word and file select
  always_ff @(posedge clk) begin
    if (rst) begin
      cmd_reg  <= 32'h0000_0000;
      file_sel <= 7'h00;
    end else if (do_write) begin
      if (aw_addr == ASX_CMD_ADDR) cmd_reg <= next_cmd;
      if (aw_addr == ASX_FSEL_ADDR && w_strb[0]) file_sel <= w_data[6:0];
    end
  end

  // File memory has no reset; software initialises what it uses
  always_ff @(posedge clk) begin
    if (to_file) begin
      file_mem[cmd_f] <= alu_result;
    end else if (do_write && aw_addr == ASX_FDATA_ADDR && w_strb[0]) begin
      file_mem[file_sel] <= w_data[7:0];
    end
  end

  // Working register
  always_ff @(posedge clk) begin
    if (rst) begin
      w_reg <= ASX_W_RESET;
    end else if (to_w) begin
      w_reg <= alu_result;
    end else if (do_write && aw_addr == ASX_W_ADDR && w_strb[0]) begin
      w_reg <= w_data[7:0];
    end
  end

  // Arithmetic flags; an executing operation wins over a software write
  // Swap and direction load leave every flag alone
  always_ff @(posedge clk) begin
    if (rst) begin
      carry_flag       <= 1'b0;
      digit_carry_flag <= 1'b0;
      zero_flag        <= 1'b0;
    end else if (exec && (alu_upd_c || alu_upd_z)) begin
      if (alu_upd_c) begin
        carry_flag       <= alu_c;
        digit_carry_flag <= alu_dc;
      end
      zero_flag <= alu_z;
    end else if (do_write && aw_addr == ASX_STATUS_ADDR && w_strb[0]) begin
      carry_flag       <= w_data[ASX_ST_C];
      digit_carry_flag <= w_data[ASX_ST_DC];
      zero_flag        <= w_data[ASX_ST_Z];
    end
  end

  // Sleep state and power status; both flags read one after power-up
  // Sleep and wake come from different registers, so they never meet
  always_ff @(posedge clk) begin
    if (rst) begin
      sleep_mode      <= 1'b0;
      power_down_flag <= 1'b1;
      timeout_flag    <= 1'b1;
    end else if (sleep_exec) begin
      sleep_mode      <= 1'b1;
      power_down_flag <= 1'b0;
      timeout_flag    <= 1'b1;
    end else if (wake) begin
      sleep_mode <= 1'b0;
    end
  end

  // Watchdog counts prescaler overflows; sleep restarts both from zero
  always_ff @(posedge clk) begin
    if (rst || sleep_exec) begin
      watchdog_counter   <= ASX_WDOG_RESET;
      watchdog_prescaler <= ASX_PRE_RESET;
    end else begin
      // Eight-bit prescaler: one counter step every 256 clocks
      watchdog_prescaler <= watchdog_prescaler + 8'h01;
      if (watchdog_prescaler == 8'hFF) watchdog_counter <= watchdog_counter + 8'h01;
    end
  end

  // Port direction registers; other operand values are ignored
  always_ff @(posedge clk) begin
    if (rst) begin
      port_a_direction <= ASX_DIR_RESET;
      port_b_direction <= ASX_DIR_RESET;
      port_c_direction <= ASX_DIR_RESET;
    end else if (exec && cmd_op == ASX_OP_DIRECTION_LOAD) begin
      if (cmd_f == ASX_DIR_SEL_A) port_a_direction <= w_reg;
      if (cmd_f == ASX_DIR_SEL_B) port_b_direction <= w_reg;
      if (cmd_f == ASX_DIR_SEL_C) port_c_direction <= w_reg;
    end
  end

  // Read channel, answered one cycle after the address is taken
  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= ASX_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= mapped(s_axi_araddr) ? ASX_RESP_OKAY : ASX_RESP_SLVERR;
      // Data is captured with the address and stands until rready
      case (s_axi_araddr)
        ASX_CMD_ADDR:    s_axi_rdata <= cmd_reg;
        ASX_W_ADDR:      s_axi_rdata <= {24'h000000, w_reg};
        ASX_STATUS_ADDR: s_axi_rdata <= {26'h0000000, sleep_mode, timeout_flag,
                                         power_down_flag, zero_flag, digit_carry_flag,
                                         carry_flag};
        ASX_FSEL_ADDR:   s_axi_rdata <= {25'h0000000, file_sel};
        ASX_FDATA_ADDR:  s_axi_rdata <= {24'h000000, file_mem[file_sel]};
        ASX_DIRA_ADDR:   s_axi_rdata <= {24'h000000, port_a_direction};
        ASX_DIRB_ADDR:   s_axi_rdata <= {24'h000000, port_b_direction};
        ASX_DIRC_ADDR:   s_axi_rdata <= {24'h000000, port_c_direction};
        ASX_WDOG_ADDR:   s_axi_rdata <= {24'h000000, watchdog_counter};
        default:         s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule : asx_core

// *** asx_core_asserts.sv ***
// Checker for the datapath's bus handshakes and core-state outputs.
// Assumes it is bound to asx_core and sees only that module's ports.
`timescale 1ns/1ps
module asx_core_asserts (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Core state
  input wire logic [7:0]  port_a_direction,
  input wire logic [7:0]  port_b_direction,
  input wire logic [7:0]  port_c_direction,
  input wire logic        sleep_mode,
  input wire logic        power_down_flag,
  input wire logic        timeout_flag
);
  // Reset seen one edge late, so the edge that releases it stays masked
  logic rst_d;
  always_ff @(posedge clk) rst_d <= rst;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst || rst_d);

  // Sleep entry flags, and sleep exit tied to the write that causes it
  property p_sleep_pd; $rose(sleep_mode) |-> !power_down_flag; endproperty
  a_sleep_pd: assert property (p_sleep_pd) else $error("power-down flag kept");
  property p_sleep_to; $rose(sleep_mode) |-> timeout_flag; endproperty
  a_sleep_to: assert property (p_sleep_to) else $error("time-out flag low");
  property p_pd_fall; $fell(power_down_flag) |-> $rose(sleep_mode); endproperty
  a_pd_fall: assert property (p_pd_fall) else $error("power-down cleared alone");
  property p_wake; $fell(sleep_mode) |-> $rose(s_axi_bvalid); endproperty
  a_wake: assert property (p_wake) else $error("sleep left without write");
  property p_halt;
    sleep_mode && $past(sleep_mode) |-> $stable(port_a_direction) && $stable(port_c_direction);
  endproperty
  a_halt: assert property (p_halt) else $error("operation while asleep");
  // Direction A moves only on a command, and B and C hold while it moves
  property p_dir;
    !$stable(port_a_direction) |-> $rose(s_axi_bvalid) && $stable(port_b_direction)
      && $stable(port_c_direction);
  endproperty
  a_dir: assert property (p_dir) else $error("direction A changed badly");
  // Bus answers and holds, so commands are seen to execute
  property p_wr; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_wr: assert property (p_wr) else $error("write answer late");
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read answer dropped");
  property p_rd; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd: assert property (p_rd) else $error("read answer late");

  // Main scenarios reached
  c_sleep: cover property ($rose(sleep_mode));
  c_wake: cover property ($fell(sleep_mode));
  c_dir_c: cover property (!$stable(port_c_direction));
endmodule : asx_core_asserts

bind asx_core asx_core_asserts u_chk (.clk, .rst, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .port_a_direction,
  .port_b_direction, .port_c_direction, .sleep_mode, .power_down_flag, .timeout_flag);

// *** asx_pkg.sv ***
// Package for the subtract, XOR, swap, direction-load and sleep datapath.
// Assumes one 200 MHz clock and an AXI4-Lite register bus with 32-bit data.
package asx_pkg;

  // Register byte addresses
  localparam logic [7:0] ASX_CMD_ADDR    = 8'h00;
  localparam logic [7:0] ASX_W_ADDR      = 8'h04;
  localparam logic [7:0] ASX_STATUS_ADDR = 8'h08;
  localparam logic [7:0] ASX_FSEL_ADDR   = 8'h0C;
  localparam logic [7:0] ASX_FDATA_ADDR  = 8'h10;
  localparam logic [7:0] ASX_DIRA_ADDR   = 8'h14;
  localparam logic [7:0] ASX_DIRB_ADDR   = 8'h18;
  localparam logic [7:0] ASX_DIRC_ADDR   = 8'h1C;
  localparam logic [7:0] ASX_WDOG_ADDR   = 8'h20;

  // Command word fields
  localparam int ASX_CMD_OP_LSB   = 0;
  localparam int ASX_CMD_DEST_BIT = 4;
  localparam int ASX_CMD_F_LSB    = 8;
  localparam int ASX_CMD_LIT_LSB  = 16;

  // Status word fields
  localparam int ASX_ST_C     = 0;
  localparam int ASX_ST_DC    = 1;
  localparam int ASX_ST_Z     = 2;
  localparam int ASX_ST_PD    = 3;
  localparam int ASX_ST_TO    = 4;
  localparam int ASX_ST_SLEEP = 5;
  localparam int ASX_ST_WAKE  = 8;

  // Direction-load operand values
  localparam logic [6:0] ASX_DIR_SEL_A = 7'h05;
  localparam logic [6:0] ASX_DIR_SEL_B = 7'h06;
  localparam logic [6:0] ASX_DIR_SEL_C = 7'h07;

  // Values after reset
  localparam logic [7:0] ASX_DIR_RESET  = 8'hFF;
  localparam logic [7:0] ASX_W_RESET    = 8'h00;
  localparam logic [7:0] ASX_WDOG_RESET = 8'h00;
  localparam logic [7:0] ASX_PRE_RESET  = 8'h00;

  // AXI response codes
  localparam logic [1:0] ASX_RESP_OKAY   = 2'h0;
  localparam logic [1:0] ASX_RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    ASX_OP_NONE                    = 4'h0,
    ASX_OP_FILE_SUBTRACT           = 4'h1,
    ASX_OP_FILE_SUBTRACT_BORROW    = 4'h2,
    ASX_OP_NIBBLE_SWAP             = 4'h3,
    ASX_OP_LITERAL_XOR             = 4'h4,
    ASX_OP_FILE_XOR                = 4'h5,
    ASX_OP_DIRECTION_LOAD          = 4'h6,
    ASX_OP_SLEEP                   = 4'h7
  } asx_op_t;

endpackage : asx_pkg
